// File: design/fgt_pkg.sv
package fgt_pkg;

    // =====================================================================
    // geometry
    // =====================================================================
    localparam int FGT_CELLS       = 4;
    localparam int TILE_DIM        = 2;
    localparam int CELL_INS        = 2;
    localparam int SRC_COUNT       = 7;
    localparam int LOCAL_SRCS      = 5;
    localparam int ZONE_SRCS       = 2;
    localparam int NBR_FANOUT      = 8;
    localparam int MBUS_MAX        = 4;
    localparam int ZONE_DIM        = 10;
    localparam int ZONE_PORT_CELLS = 20;
    localparam int ZONE_CLK_CELLS  = 1;
    localparam int QUADRANTS       = 4;
    localparam int SRC_W           = 3;
    localparam int POS_W           = 4;
    localparam int QUAD_W          = 2;

    typedef logic [SRC_W-1:0]  fgt_src_t;
    typedef logic [POS_W-1:0]  fgt_pos_t;
    typedef logic [QUAD_W-1:0] fgt_quad_t;

    // sources 0..4 local neighbours, 5..6 zone buses, 7 unused
    localparam fgt_src_t SRC_ZONE_BASE = 3'h5;
    localparam fgt_src_t SRC_ZONE_LAST = 3'h6;

    typedef enum logic [1:0] {
        FGT_MODE_BUF,
        FGT_MODE_NAND,
        FGT_MODE_SEC
    } fgt_mode_t;

    typedef enum logic [1:0] {
        FGT_SEC_XOR,
        FGT_SEC_STORE,
        FGT_SEC_OD_OR,
        FGT_SEC_OD_NAND
    } fgt_sec_t;

    // =====================================================================
    // per-position secondary function of the tile
    // =====================================================================
    function automatic fgt_sec_t fgt_sec_of(input int idx);
        unique case (idx)
            0:       fgt_sec_of = FGT_SEC_XOR;
            1:       fgt_sec_of = FGT_SEC_STORE;
            2:       fgt_sec_of = FGT_SEC_OD_OR;
            default: fgt_sec_of = FGT_SEC_OD_NAND;
        endcase
    endfunction : fgt_sec_of

    // =====================================================================
    // timing of the open-drain net
    // =====================================================================
    localparam int CLK_PERIOD_PS   = 10000;
    localparam int PS_PER_NS       = 1000;
    localparam int PU_ONE_RISE_NS  = 40;
    localparam int PU_BOTH_RISE_NS = 20;
    localparam int RISE_CNT_W      = 3;
    localparam logic [RISE_CNT_W-1:0] PU_ONE_RISE_CYC =
        RISE_CNT_W'((PU_ONE_RISE_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [RISE_CNT_W-1:0] PU_BOTH_RISE_CYC =
        RISE_CNT_W'((PU_BOTH_RISE_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [RISE_CNT_W-1:0] RISE_CNT_STEP = 3'h1;

    // =====================================================================
    // reset values
    // =====================================================================
    localparam logic OD_NET_RST   = 1'b1;
    localparam logic STORE_Q_RST  = 1'b0;

endpackage : fgt_pkg

// File: design/fgt_cell.sv
`timescale 1ns/10ps
module fgt_cell #(
    parameter fgt_pkg::fgt_sec_t SEC_KIND = fgt_pkg::FGT_SEC_XOR
) (
    input  wire logic [fgt_pkg::LOCAL_SRCS-1:0]           local_src,
    input  wire logic [fgt_pkg::ZONE_SRCS-1:0]            zone_src,
    input  wire logic [fgt_pkg::CELL_INS-1:0][fgt_pkg::SRC_W-1:0] src_sel,
    input  wire logic [fgt_pkg::CELL_INS-1:0]             inverter_element,
    input  wire fgt_pkg::fgt_mode_t                       mode,
    input  wire logic                                     store_q,
    output logic      [fgt_pkg::CELL_INS-1:0]             in_eff,
    output logic                                          y,
    output logic                                          pull_low
);
    import fgt_pkg::*;

    logic [SRC_COUNT-1:0] srcs;

    assign srcs = {zone_src, local_src};

    // =====================================================================
    // input selection and inversion
    // =====================================================================
    always_comb begin
        for (int k = 0; k < CELL_INS; k++) begin
            if (src_sel[k] <= SRC_ZONE_LAST) begin
                in_eff[k] = srcs[src_sel[k]] ^ inverter_element[k];
            end else begin
                in_eff[k] = inverter_element[k];
            end
        end
    end

    // =====================================================================
    // cell state
    // =====================================================================
    always_comb begin
        y        = in_eff[0];
        pull_low = 1'b0;
        unique case (mode)
            FGT_MODE_BUF:  y = in_eff[0];
            FGT_MODE_NAND: y = ~(in_eff[0] & in_eff[1]);
            FGT_MODE_SEC: begin
                unique case (SEC_KIND)
                    FGT_SEC_XOR:     y = in_eff[0] ^ in_eff[1];
                    FGT_SEC_STORE:   y = store_q;
                    FGT_SEC_OD_OR: begin
                        pull_low = ~(in_eff[0] | in_eff[1]);
                        y        = ~pull_low;
                    end
                    FGT_SEC_OD_NAND: begin
                        pull_low = in_eff[0] & in_eff[1];
                        y        = ~pull_low;
                    end
                endcase
            end
            default: y = in_eff[0];
        endcase
    end

endmodule : fgt_cell

// File: design/fgt_store.sv
`timescale 1ns/10ps
module fgt_store (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic d,
    input  wire logic ce,
    input  wire logic ck_pulse,
    input  wire logic ck_level,
    input  wire logic latch_mode,
    input  wire logic sr_assert,
    input  wire logic sr_is_set,
    output logic      q
);
    import fgt_pkg::*;

    typedef struct packed {
        logic q;
    } fgt_store_st_t;

    fgt_store_st_t st_ff;
    fgt_store_st_t nxt_st;

    // =====================================================================
    // flip-flop or latch, clock enable, set or reset priority
    // =====================================================================
    always_comb begin
        nxt_st = st_ff;
        if (sr_assert) begin
            nxt_st.q = sr_is_set;
        end else if (ce && latch_mode && ck_level) begin
            nxt_st.q = d;
        end else if (ce && !latch_mode && ck_pulse) begin
            nxt_st.q = d;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_ff.q <= STORE_Q_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.q;

endmodule : fgt_store

// File: design/fgt_tile.sv
`timescale 1ns/10ps
module fgt_tile #(
    parameter fgt_pkg::fgt_pos_t  TILE_COL  = 4'h0,
    parameter fgt_pkg::fgt_pos_t  TILE_ROW  = 4'h0,
    parameter fgt_pkg::fgt_quad_t TILE_QUAD = 2'h0
) (
    input  wire logic                                                         clk_sys,
    input  wire logic                                                         arst_n,
    input  wire logic                                                         cfg_wr,
    input  wire logic [fgt_pkg::FGT_CELLS-1:0][fgt_pkg::CELL_INS-1:0][fgt_pkg::SRC_W-1:0] cfg_src_sel,
    input  wire logic [fgt_pkg::FGT_CELLS-1:0][fgt_pkg::CELL_INS-1:0]         cfg_inv,
    input  wire logic [fgt_pkg::FGT_CELLS-1:0][1:0]                           cfg_mode,
    input  wire logic [fgt_pkg::FGT_CELLS-1:0][fgt_pkg::MBUS_MAX-1:0]         cfg_mbus_en,
    input  wire logic                                                         cfg_store_latch,
    input  wire logic                                                         cfg_store_set,
    input  wire logic                                                         cfg_pull_both,
    input  wire logic [fgt_pkg::FGT_CELLS-1:0][fgt_pkg::LOCAL_SRCS-1:0]       local_in,
    input  wire logic [fgt_pkg::FGT_CELLS-1:0][fgt_pkg::ZONE_SRCS-1:0]        zone_in,
    input  wire logic                                                         ck_net_pulse,
    input  wire logic                                                         ck_net_level,
    input  wire logic                                                         store_ce,
    input  wire logic                                                         sr_net,
    input  wire logic                                                         od_ext_low,
    output logic      [fgt_pkg::FGT_CELLS-1:0]                                cell_out,
    output logic      [fgt_pkg::FGT_CELLS-1:0][fgt_pkg::NBR_FANOUT-1:0]       nbr_out,
    output logic      [fgt_pkg::FGT_CELLS-1:0][fgt_pkg::MBUS_MAX-1:0]         mbus_val,
    output logic      [fgt_pkg::FGT_CELLS-1:0][fgt_pkg::MBUS_MAX-1:0]         mbus_drv,
    output logic                                                              od_pull_low,
    output logic                                                              od_net,
    output logic      [fgt_pkg::POS_W-1:0]                                    od_bus_col,
    output logic      [fgt_pkg::POS_W-1:0]                                    tile_row_pos,
    output logic      [fgt_pkg::QUAD_W-1:0]                                   tile_quad
);
    import fgt_pkg::*;

    // =====================================================================
    // state
    // =====================================================================
    typedef struct packed {
        logic [FGT_CELLS-1:0][CELL_INS-1:0][SRC_W-1:0] src_sel;
        logic [FGT_CELLS-1:0][CELL_INS-1:0]            inverter_element;
        logic [FGT_CELLS-1:0][1:0]                     mode;
        logic [FGT_CELLS-1:0][MBUS_MAX-1:0]            mbus_en;
        logic                                          store_latch;
        logic                                          store_set;
        logic                                          pull_both;
        logic [FGT_CELLS-1:0]                          cell_out;
        logic [FGT_CELLS-1:0][NBR_FANOUT-1:0]          nbr_out;
        logic [FGT_CELLS-1:0][MBUS_MAX-1:0]            mbus_val;
        logic [FGT_CELLS-1:0][MBUS_MAX-1:0]            mbus_drv;
        logic                                          od_pull_low;
        logic                                          od_net;
        logic [RISE_CNT_W-1:0]                         rise_cnt;
        logic [POS_W-1:0]                              od_bus_col;
        logic [POS_W-1:0]                              row_pos;
        logic [QUAD_W-1:0]                             quad;
    } fgt_tile_st_t;

    fgt_tile_st_t st_ff;
    fgt_tile_st_t nxt_st;

    logic [FGT_CELLS-1:0]                cell_y;
    logic [FGT_CELLS-1:0]                cell_pd;
    logic [FGT_CELLS-1:0][CELL_INS-1:0]  cell_in;
    logic                                store_q;
    logic                                pull_low_any;
    logic [RISE_CNT_W-1:0]               rise_target;

    // =====================================================================
    // the four cells of the tile
    // =====================================================================
    genvar gi;
    generate
        for (gi = 0; gi < FGT_CELLS; gi++) begin : g_cell
            fgt_cell #(
                .SEC_KIND (fgt_sec_of(gi))
            ) u_cell (
                .local_src (local_in[gi]),
                .zone_src  (zone_in[gi]),
                .src_sel   (st_ff.src_sel[gi]),
                .inverter_element       (st_ff.inverter_element[gi]),
                .mode      (fgt_mode_t'(st_ff.mode[gi])),
                .store_q   (store_q),
                .in_eff    (cell_in[gi]),
                .y         (cell_y[gi]),
                .pull_low  (cell_pd[gi])
            );
        end
    endgenerate

    // =====================================================================
    // storage element on the tile's storage position
    // =====================================================================
    localparam int STORE_IDX = 1;

    fgt_store u_store (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .d          (cell_in[STORE_IDX][0]),
        .ce         (store_ce & cell_in[STORE_IDX][1]),
        .ck_pulse   (ck_net_pulse),
        .ck_level   (ck_net_level),
        .latch_mode (st_ff.store_latch),
        .sr_assert  (sr_net),
        .sr_is_set  (st_ff.store_set),
        .q          (store_q)
    );

    // =====================================================================
    // wired-OR net with pull-up
    // =====================================================================
    always_comb begin
        pull_low_any = od_ext_low;
        for (int c = 0; c < FGT_CELLS; c++) begin
            pull_low_any = pull_low_any | cell_pd[c];
        end
        rise_target = st_ff.pull_both ? PU_BOTH_RISE_CYC : PU_ONE_RISE_CYC;
    end

    // =====================================================================
    // next state
    // =====================================================================
    always_comb begin
        nxt_st = st_ff;

        // configuration only changes on a load strobe
        if (cfg_wr) begin
            nxt_st.src_sel     = cfg_src_sel;
            nxt_st.inverter_element         = cfg_inv;
            nxt_st.mode        = cfg_mode;
            nxt_st.mbus_en     = cfg_mbus_en;
            nxt_st.store_latch = cfg_store_latch;
            nxt_st.store_set   = cfg_store_set;
            nxt_st.pull_both   = cfg_pull_both;
        end

        for (int c = 0; c < FGT_CELLS; c++) begin
            nxt_st.cell_out[c] = cell_y[c];
            nxt_st.nbr_out[c]  = {NBR_FANOUT{cell_y[c]}};
            for (int b = 0; b < MBUS_MAX; b++) begin
                // driven only when granted: value is zero when not granted
                nxt_st.mbus_drv[c][b] = st_ff.mbus_en[c][b];
                nxt_st.mbus_val[c][b] = st_ff.mbus_en[c][b] & cell_y[c];
            end
        end

        nxt_st.od_pull_low = |cell_pd;
        if (pull_low_any) begin
            nxt_st.od_net   = 1'b0;
            nxt_st.rise_cnt = '0;
        end else if (!st_ff.od_net) begin
            if (st_ff.rise_cnt + RISE_CNT_STEP >= rise_target) begin
                nxt_st.od_net   = 1'b1;
                nxt_st.rise_cnt = '0;
            end else begin
                nxt_st.rise_cnt = st_ff.rise_cnt + RISE_CNT_STEP;
            end
        end

        nxt_st.od_bus_col = TILE_COL;
        nxt_st.row_pos    = TILE_ROW;
        nxt_st.quad       = TILE_QUAD;
    end

    // =====================================================================
    // registers
    // =====================================================================
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_ff        <= '0;
            st_ff.od_net <= OD_NET_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // =====================================================================
    // outputs
    // =====================================================================
    assign cell_out     = st_ff.cell_out;
    assign nbr_out      = st_ff.nbr_out;
    assign mbus_val     = st_ff.mbus_val;
    assign mbus_drv     = st_ff.mbus_drv;
    assign od_pull_low  = st_ff.od_pull_low;
    assign od_net       = st_ff.od_net;
    assign od_bus_col   = st_ff.od_bus_col;
    assign tile_row_pos = st_ff.row_pos;
    assign tile_quad    = st_ff.quad;

endmodule : fgt_tile

// File: sim/fgt_tile_checker.sv
`timescale 1ns/10ps
module fgt_tile_checker (
    input wire logic                                                   clk_sys,
    input wire logic                                                   arst_n,
    input wire logic                                                   cfg_wr,
    input wire logic [fgt_pkg::FGT_CELLS-1:0][1:0]                     cfg_mode,
    input wire logic                                                   cfg_store_set,
    input wire logic                                                   ck_net_pulse,
    input wire logic                                                   ck_net_level,
    input wire logic                                                   sr_net,
    input wire logic                                                   od_ext_low,
    input wire logic [fgt_pkg::FGT_CELLS-1:0]                          cell_out,
    input wire logic [fgt_pkg::FGT_CELLS-1:0][fgt_pkg::NBR_FANOUT-1:0] nbr_out,
    input wire logic [fgt_pkg::FGT_CELLS-1:0][fgt_pkg::MBUS_MAX-1:0]   mbus_val,
    input wire logic [fgt_pkg::FGT_CELLS-1:0][fgt_pkg::MBUS_MAX-1:0]   mbus_drv,
    input wire logic                                                   od_pull_low,
    input wire logic                                                   od_net
);
    import fgt_pkg::*;
    logic [FGT_CELLS-1:0][NBR_FANOUT-1:0] nbr_exp;
    logic [FGT_CELLS-1:0][MBUS_MAX-1:0]   mbus_exp;
    always_comb begin
        for (int c = 0; c < FGT_CELLS; c++) begin
            nbr_exp[c]  = {NBR_FANOUT{cell_out[c]}};
            mbus_exp[c] = {MBUS_MAX{cell_out[c]}} & mbus_drv[c];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // storage cell configured and settled
    sequence s_quiet;
        !cfg_wr && !$past(cfg_wr) && !$past(cfg_wr, 2) && !$past(cfg_wr, 3) && cfg_mode[1] == 2'h2;
    endsequence
    // ========
    // assertions
    a_nbr_copy: assert property (nbr_out == nbr_exp)
        else $error("neighbour fanout differs from cell output");
    a_mbus_gate: assert property (mbus_val == mbus_exp)
        else $error("medium bus value not gated by its grant");
    a_ext_low: assert property (od_ext_low |=> !od_net)
        else $error("net not low after another zone pulled it");
    a_own_low: assert property (od_pull_low |=> !od_net)
        else $error("net not low while tile pulls it");
    a_rise_free: assert property ($rose(od_net) |-> !$past(od_ext_low) && !$past(od_pull_low))
        else $error("net rose while still pulled low");
    a_rise_bound: assert property ((!od_ext_low && !od_pull_low) [*7] |-> od_net)
        else $error("pull-up did not restore the net");
    a_sr_value: assert property (s_quiet ##0 sr_net |-> ##2 cell_out[1] == cfg_store_set)
        else $error("storage not forced to its set or reset value");
    a_store_hold: assert property (s_quiet ##0 !sr_net && !ck_net_pulse && !ck_net_level
        |-> ##2 cell_out[1] == $past(cell_out[1]))
        else $error("storage changed without a clock");
    c_sr_hit: cover property (s_quiet ##0 sr_net);
    c_net_fall: cover property ($fell(od_net));
    c_net_rise: cover property ($rose(od_net));
endmodule : fgt_tile_checker

bind fgt_tile fgt_tile_checker fgt_tile_checker_inst (
    .clk_sys, .arst_n, .cfg_wr, .cfg_mode, .cfg_store_set, .ck_net_pulse, .ck_net_level, .sr_net,
    .od_ext_low, .cell_out, .nbr_out, .mbus_val, .mbus_drv, .od_pull_low, .od_net);

// File: sim/fgt_nbr_model.sv
`timescale 1ns/10ps
module fgt_nbr_model (
    input  wire logic                                                   clk_sys,
    input  wire logic [fgt_pkg::FGT_CELLS-1:0][fgt_pkg::LOCAL_SRCS-1:0] want_local,
    input  wire logic [fgt_pkg::FGT_CELLS-1:0][fgt_pkg::ZONE_SRCS-1:0]  want_zone,
    input  wire logic                                                   want_low,
    input  wire logic                                                   slow,
    output logic      [fgt_pkg::FGT_CELLS-1:0][fgt_pkg::LOCAL_SRCS-1:0] local_in,
    output logic      [fgt_pkg::FGT_CELLS-1:0][fgt_pkg::ZONE_SRCS-1:0]  zone_in,
    output logic                                                        od_ext_low
);
    import fgt_pkg::*;
    logic late_ff;
    initial {local_in, zone_in, late_ff, od_ext_low} = '0;
    // neighbours switch on the falling edge, clear of the sampling edge
    always @(negedge clk_sys) begin
        local_in   <= want_local;
        zone_in    <= want_zone;
        late_ff    <= want_low;
        od_ext_low <= want_low | (slow & late_ff);
    end
endmodule : fgt_nbr_model

// File: sim/test_fine_grain_logic_tile.sv
`timescale 1ns/10ps
module test_fine_grain_logic_tile;
    import fgt_pkg::*;
    localparam fgt_pos_t  COL  = 4'h3;
    localparam fgt_pos_t  ROW  = 4'h5;
    localparam fgt_quad_t QUAD = 2'h2;
    logic                                          clk_sys, arst_n, cfg_wr, cfg_store_latch, cfg_store_set;
    logic                                          cfg_pull_both, ck_net_pulse, ck_net_level, store_ce, sr_net;
    logic                                          want_low, slow, od_pull_low, od_ext_low, od_net;
    logic [FGT_CELLS-1:0][CELL_INS-1:0][SRC_W-1:0] cfg_src_sel;
    logic [FGT_CELLS-1:0][CELL_INS-1:0]            cfg_inv;
    logic [FGT_CELLS-1:0][1:0]                     cfg_mode;
    logic [FGT_CELLS-1:0][MBUS_MAX-1:0]            cfg_mbus_en, mbus_val, mbus_drv;
    logic [FGT_CELLS-1:0][LOCAL_SRCS-1:0]          want_local, local_in;
    logic [FGT_CELLS-1:0][ZONE_SRCS-1:0]           want_zone, zone_in;
    logic [FGT_CELLS-1:0]                          cell_out, ex;
    logic [FGT_CELLS-1:0][NBR_FANOUT-1:0]          nbr_out;
    logic [POS_W-1:0]                              od_bus_col, tile_row_pos;
    logic [QUAD_W-1:0]                             tile_quad;
    int                                            num_errors, cmp_count, rise_cnt[2];

    fgt_tile #(.TILE_COL(COL), .TILE_ROW(ROW), .TILE_QUAD(QUAD)) fgt_tile_inst (
        .clk_sys, .arst_n, .cfg_wr, .cfg_src_sel, .cfg_inv, .cfg_mode, .cfg_mbus_en, .cfg_store_latch,
        .cfg_store_set, .cfg_pull_both, .local_in, .zone_in, .ck_net_pulse, .ck_net_level, .store_ce,
        .sr_net, .od_ext_low, .cell_out, .nbr_out, .mbus_val, .mbus_drv, .od_pull_low, .od_net,
        .od_bus_col, .tile_row_pos, .tile_quad);
    fgt_nbr_model fgt_nbr_model_inst (
        .clk_sys, .want_local, .want_zone, .want_low, .slow, .local_in, .zone_in, .od_ext_low);

    // ========
    // expectation
    function automatic logic eff(int c, int i);
        logic s;
        s = (cfg_src_sel[c][i] < SRC_ZONE_BASE) ? local_in[c][cfg_src_sel[c][i]] :
            (cfg_src_sel[c][i] == 3'h7) ? 1'b0 : zone_in[c][cfg_src_sel[c][i] - SRC_ZONE_BASE];
        return s ^ cfg_inv[c][i];
    endfunction : eff

    function automatic logic cell_exp(int c);
        case (cfg_mode[c])
            2'h1:    return ~(eff(c, 0) & eff(c, 1));
            // secondaries by position: xor, idle storage, wired-or, wired-nand driver
            2'h2: begin
                case (c)
                    0:       return eff(c, 0) ^ eff(c, 1);
                    1:       return STORE_Q_RST;
                    2:       return eff(c, 0) | eff(c, 1);
                    default: return ~(eff(c, 0) & eff(c, 1));
                endcase
            end
            default: return eff(c, 0);
        endcase
    endfunction : cell_exp

    // ========
    // tasks
    task automatic check(logic [15:0] got, logic [15:0] want, string what);
        cmp_count++;
        if (got !== want) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask : check

    task automatic load;
        cfg_wr = 1'b1;
        @(negedge clk_sys);
        cfg_wr = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask : load

    // neighbours settle one falling edge later, result one cycle after that
    task automatic apply(logic [19:0] lv, logic [7:0] zv);
        want_local <= lv;
        want_zone  <= zv;
        @(negedge clk_sys);
        #1;
        for (int c = 0; c < FGT_CELLS; c++) ex[c] = cell_exp(c);
        @(negedge clk_sys);
    endtask : apply

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        @(negedge clk_sys);
        sig = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask : pulse

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test

    // ========
    // stimulus
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #100000;
        num_errors++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h2797c261));
        {arst_n, cfg_wr, cfg_store_latch, cfg_store_set, cfg_pull_both, want_low, slow} = '0;
        {ck_net_pulse, ck_net_level, store_ce, sr_net} = '0;
        {cfg_src_sel, cfg_inv, cfg_mode, cfg_mbus_en, want_local, want_zone} = '0;
        num_errors = 0;
        cmp_count = 0;
        repeat (3) @(negedge clk_sys);
        check(od_net, 1'b1, "idle net level");
        arst_n = 1'b1;
        @(negedge clk_sys);
        // random configurations against random neighbour and zone traffic
        repeat (40) begin
            cfg_src_sel = 24'($urandom);
            cfg_inv     = 8'($urandom);
            cfg_mode    = 8'($urandom);
            cfg_mbus_en = 16'($urandom);
            load();
            check(mbus_drv, cfg_mbus_en, "medium bus grants");
            repeat (8) begin
                apply(20'($urandom), 8'($urandom));
                for (int c = 0; c < FGT_CELLS; c++)
                    check(cell_out[c], ex[c], "cell output");
            end
        end
        // storage cell: both modes, set and reset, clock with and without enable
        cfg_mode       = 8'h08;
        cfg_src_sel    = '0;
        cfg_src_sel[1][1] = 3'h7;
        cfg_inv        = '0;
        cfg_inv[1][1]  = 1'b1;
        for (int k = 0; k < 4; k++) begin
            {cfg_store_latch, cfg_store_set} = 2'(k);
            load();
            pulse(sr_net);
            check(cell_out[1], cfg_store_set, "set or reset value");
            apply({20{~cfg_store_set}}, 8'h00);
            for (int e = 0; e < 2; e++) begin
                store_ce = e[0];
                if (cfg_store_latch) pulse(ck_net_level);
                else pulse(ck_net_pulse);
                check(cell_out[1], cfg_store_set ^ e[0], "stored value");
            end
        end
        // open-drain drivers of cells 2 and 3, one and two pull-ups
        cfg_mode    = 8'hA0;
        cfg_src_sel = '0;
        cfg_inv     = '0;
        for (int k = 0; k < 2; k++) begin
            cfg_pull_both = k[0];
            load();
            for (int v = 0; v < 4; v++) begin
                apply(20'({v[1], 4'h0, v[0]}) << 10, 8'h00);
                check(od_pull_low, !v[0] || v[1], "tile pull-down");
            end
            apply(20'h00400, 8'h00);
            rise_cnt[k] = 0;
            while (od_net !== 1'b1 && rise_cnt[k] < 20) begin
                rise_cnt[k]++;
                @(negedge clk_sys);
            end
            // first quiet edge lies inside apply, so one edge fewer is left to wait
            check(16'(rise_cnt[k]), 16'((k[0] ? PU_BOTH_RISE_CYC : PU_ONE_RISE_CYC) - 1), "pull-up rise time");
            want_low <= 1'b1;
            slow     <= k[0];
            repeat (3) @(negedge clk_sys);
            check(od_net, 1'b0, "net held by another zone");
            check(od_pull_low, 1'b0, "tile pull-down");
            want_low <= 1'b0;
            repeat (8) @(negedge clk_sys);
        end
        check(rise_cnt[1] < rise_cnt[0] && rise_cnt[0] < 20, 1'b1, "pull-up rise order");
        check({od_bus_col, tile_row_pos, tile_quad}, {COL, ROW, QUAD}, "tile position");
        end_of_test();
    end
endmodule : test_fine_grain_logic_tile
